// ### rtl/adc_i2c_pkg.sv
package adc_i2c_pkg;

    // Bus addresses, 7 bits each
    localparam logic [6:0] OWN_ADDR = 7'h14;
    localparam logic [6:0] GLOBAL_ADDR = 7'h77;

    // Configuration byte layout and reset value
    localparam int CFG_RATE_BIT = 7;
    localparam logic SLOW_RATE_RESET = 1'b0;

    // Result word
    localparam int RESULT_W = 16;
    localparam int BYTE_W = 8;

    // Timing: the fast-mode conversion period sets the sinc1 notch
    localparam int CLK_PERIOD_NS = 50;
    localparam int CONV_TIME_FAST_NS = 16666667;
    localparam int CONV_CYCLES_FAST = CONV_TIME_FAST_NS / CLK_PERIOD_NS;
    localparam int FAST_SAMPLES = 65535;
    localparam int SAMPLE_DIV_DEF = CONV_CYCLES_FAST / FAST_SAMPLES;

    // Serial port phases
    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_ADDR = 3'b001,
        PH_ADDR_ACK = 3'b010,
        PH_WDATA = 3'b011,
        PH_WDATA_ACK = 3'b100,
        PH_RDATA = 3'b101,
        PH_RMACK = 3'b110,
        PH_IGNORE = 3'b111
    } phase_t;

endpackage : adc_i2c_pkg

// ### rtl/adc_i2c_conversion_restart.sv
`timescale 1ns/10ps
`default_nettype none

// Operation
// R01 - An acknowledged write ended by Stop discards the result and starts a conversion.
// R02 - A configuration byte after the write address is applied at Stop, then conversion restarts.
// R03 - The master uses the global call only after conversions have completed.
// R04 - Global address 1110111 with write is acknowledged by every idle converter.
// R05 - After the global address the master may send one rate byte.
// R06 - Stop ending a global write loads any received byte, then starts conversion.
// R07 - Stop straight after the address ack restarts conversion, configuration kept.
// R08 - The result comes from a first-order sinc filter notched at the fast rate.
// R09 - Own address 0010100 is NAKed while converting and ACKed when done.
// R10 - Configuration bit 7 high picks slow rate, low fast; fast after reset.
// R11 - Reads shift out 16 result bits MSB first on falling SCL.
// R12 - After write, Sr, read: restart after 16 bits or Stop, new configuration.
// R13 - A NAKed write changes nothing and restarts nothing at Stop.
module adc_i2c_conversion_restart #(
    parameter int SAMPLE_DIV = adc_i2c_pkg::SAMPLE_DIV_DEF,
    parameter int CONV_SAMPLES = adc_i2c_pkg::FAST_SAMPLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic modBit,
    output logic slowRateSelect,
    output logic convBusy,
    output logic [adc_i2c_pkg::RESULT_W-1:0] resultData
);
    import adc_i2c_pkg::*;

    if (SAMPLE_DIV < 1 || SAMPLE_DIV > 255 || CONV_SAMPLES < 1 || CONV_SAMPLES > FAST_SAMPLES) begin : g_badParam
        $error("adc_i2c_conversion_restart: SAMPLE_DIV or CONV_SAMPLES out of range");
    end

    localparam logic [16:0] FAST_N = 17'(CONV_SAMPLES);
    localparam logic [16:0] SLOW_N = 17'(2 * CONV_SAMPLES);
    localparam logic [7:0] DIV_LAST = 8'(SAMPLE_DIV - 1);

    typedef struct packed {
        logic sclS1;
        logic sclS2;
        logic sclPrev;
        logic sdaS1;
        logic sdaS2;
        logic sdaPrev;
        phase_t phase;
        logic [2:0] bitCnt;
        logic [BYTE_W-1:0] shiftIn;
        logic rwBit;
        logic ackPh;
        logic byteIdx;
        logic [RESULT_W-1:0] dataOut;
        logic sdaOe;
        logic wrAcked;
        logic rdAcked;
        logic cfgValid;
        logic cfgRate;
        logic slowRate;
        logic converting;
        logic [7:0] divCnt;
        logic [16:0] sampleCnt;
        logic [16:0] acc;
        logic [RESULT_W-1:0] result;
    } state_t;

    // Lines idle high so a reset never looks like a Start; POR begins a conversion
    localparam state_t RESET_STATE = '{sclS1: 1'b1, sclS2: 1'b1, sclPrev: 1'b1, sdaS1: 1'b1, sdaS2: 1'b1,
        sdaPrev: 1'b1, phase: PH_IDLE, slowRate: SLOW_RATE_RESET, converting: 1'b1, default: '0};

    state_t st_reg;
    state_t st_next;

    // Address decode used by the FSM; the checks compare against GLOBAL_ADDR directly
    function automatic logic addrHit(input logic [BYTE_W-1:0] b);
        addrHit = (b[7:1] == OWN_ADDR) || (b[7:1] == GLOBAL_ADDR && !b[0]);
    endfunction : addrHit

    // Sinc1 sum scaled to the result width; slow mode sums twice as long
    function automatic logic [RESULT_W-1:0] scaleSum(input logic [16:0] s, input logic slow);
        scaleSum = slow ? s[16:1] : (s[16] ? 16'hffff : s[15:0]);
    endfunction : scaleSum

    logic sclRise;
    logic sclFall;
    logic startSeen;
    logic stopSeen;
    logic restart;
    logic [BYTE_W-1:0] inByte;
    logic convEnd;

    // Bus event decode works only on the second sync stage and its delayed copy
    assign sclRise = st_reg.sclS2 && !st_reg.sclPrev;
    assign sclFall = !st_reg.sclS2 && st_reg.sclPrev;
    assign startSeen = st_reg.sclS2 && st_reg.sclPrev && st_reg.sdaPrev && !st_reg.sdaS2;
    assign stopSeen = st_reg.sclS2 && st_reg.sclPrev && !st_reg.sdaPrev && st_reg.sdaS2;
    assign inByte = {st_reg.shiftIn[6:0], st_reg.sdaS2};
    assign convEnd = st_reg.converting && st_reg.divCnt == DIV_LAST
        && st_reg.sampleCnt == (st_reg.slowRate ? SLOW_N : FAST_N);

    // Next-state logic for the serial port and the conversion engine
    always_comb begin
        st_next = st_reg;
        restart = 1'b0;
        st_next.sclS1 = sclIn;
        st_next.sclS2 = st_reg.sclS1;
        st_next.sclPrev = st_reg.sclS2;
        st_next.sdaS1 = sdaIn;
        st_next.sdaS2 = st_reg.sdaS1;
        st_next.sdaPrev = st_reg.sdaS2;
        if (stopSeen) begin
            // Only a transfer we acknowledged may restart; a NAKed one leaves all alone
            restart = st_reg.wrAcked || st_reg.rdAcked; // R01 R07 R12 R13
            st_next.phase = PH_IDLE;
            st_next.sdaOe = 1'b0;
        end else if (startSeen) begin
            // Repeated Start keeps any pending write so it applies later
            st_next.phase = PH_ADDR;
            st_next.bitCnt = 3'h0;
            st_next.ackPh = 1'b0;
            st_next.sdaOe = 1'b0;
        end else begin
            unique case (st_reg.phase)
                PH_IDLE, PH_IGNORE: begin
                end
                PH_ADDR, PH_WDATA: begin
                    if (sclRise) begin
                        st_next.shiftIn = inByte;
                        st_next.bitCnt = st_reg.bitCnt + 3'h1;
                        if (st_reg.bitCnt == 3'h7) begin
                            if (st_reg.phase == PH_WDATA) begin
                                st_next.cfgRate = inByte[CFG_RATE_BIT]; // R02 R05 R10
                                st_next.cfgValid = 1'b1;
                                st_next.phase = PH_WDATA_ACK;
                            end else if (addrHit(inByte) && !st_reg.converting) begin
                                st_next.rwBit = inByte[0]; // R04 R09
                                st_next.phase = PH_ADDR_ACK;
                            end else begin
                                st_next.phase = PH_IGNORE; // R09 R13
                            end
                        end
                    end
                end
                PH_ADDR_ACK, PH_WDATA_ACK: begin
                    if (sclFall && !st_reg.ackPh) begin
                        st_next.sdaOe = 1'b1;
                        st_next.ackPh = 1'b1;
                        if (st_reg.phase == PH_ADDR_ACK) begin
                            st_next.wrAcked = st_reg.wrAcked || !st_reg.rwBit; // R01 R06
                            st_next.rdAcked = st_reg.rdAcked || st_reg.rwBit;
                            st_next.dataOut = st_reg.result;
                            st_next.byteIdx = 1'b0;
                        end
                    end else if (sclFall) begin
                        // End of the ack clock: hand the line to the first data bit
                        st_next.ackPh = 1'b0;
                        st_next.bitCnt = 3'h0;
                        if (st_reg.phase == PH_ADDR_ACK && st_reg.rwBit) begin
                            st_next.phase = PH_RDATA;
                            st_next.sdaOe = !st_reg.dataOut[RESULT_W-1]; // R11
                        end else begin
                            st_next.phase = PH_WDATA;
                            st_next.sdaOe = 1'b0;
                        end
                    end
                end
                PH_RDATA: begin
                    if (sclFall) begin
                        st_next.sdaOe = !st_reg.dataOut[RESULT_W-1]; // R11
                    end else if (sclRise) begin
                        st_next.dataOut = {st_reg.dataOut[RESULT_W-2:0], 1'b0};
                        st_next.bitCnt = st_reg.bitCnt + 3'h1;
                        if (st_reg.bitCnt == 3'h7) begin
                            st_next.phase = PH_RMACK;
                        end
                    end
                end
                PH_RMACK: begin
                    if (sclFall && !st_reg.ackPh) begin
                        st_next.sdaOe = 1'b0;
                        st_next.ackPh = 1'b1;
                    end else if (sclRise && st_reg.ackPh) begin
                        st_next.ackPh = 1'b0;
                        if (st_reg.byteIdx) begin
                            restart = 1'b1; // R12
                            st_next.phase = PH_IGNORE;
                        end else if (st_reg.sdaS2) begin
                            st_next.phase = PH_IGNORE;
                        end else begin
                            st_next.byteIdx = 1'b1;
                            st_next.phase = PH_RDATA;
                        end
                    end
                end
            endcase
        end
        // Sinc1: boxcar count of modulator ones over one conversion period
        if (st_reg.converting) begin
            st_next.divCnt = (st_reg.divCnt == DIV_LAST) ? 8'h00 : st_reg.divCnt + 8'h01;
            if (st_reg.divCnt == DIV_LAST) begin
                st_next.sampleCnt = st_reg.sampleCnt + 17'h1;
                st_next.acc = st_reg.acc + {16'h0000, modBit};
            end
        end
        if (convEnd) begin
            st_next.result = scaleSum(st_reg.acc, st_reg.slowRate); // R08
            st_next.converting = 1'b0;
        end
        // Restart discards the result under way and applies any pending rate byte
        if (restart) begin
            if (st_reg.cfgValid) begin
                st_next.slowRate = st_reg.cfgRate; // R02 R06 R12
            end
            st_next.cfgValid = 1'b0;
            st_next.wrAcked = 1'b0;
            st_next.rdAcked = 1'b0;
            st_next.converting = 1'b1; // R01 R07
            st_next.divCnt = 8'h00;
            st_next.sampleCnt = 17'h0;
            st_next.acc = 17'h0;
        end
    end

    // All state in one register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg <= RESET_STATE;
        end else begin
            st_reg <= st_next;
        end
    end

    // Open-drain: we only ever pull low
    assign sdaOut = 1'b0;
    assign sdaOe = st_reg.sdaOe;
    assign slowRateSelect = st_reg.slowRate;
    assign convBusy = st_reg.converting;
    assign resultData = st_reg.result;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_ack_only_idle: assert property ((st_reg.phase == PH_ADDR_ACK && st_reg.sdaOe) |-> !st_reg.converting) // R09
        else $error("address acknowledged during conversion");
    a_stop_restart: assert property ((stopSeen && st_reg.wrAcked) |=> (convBusy && st_reg.sampleCnt == 17'h0)) // R01
        else $error("acked write with Stop did not restart conversion");
    a_cfg_apply: assert property ((stopSeen && st_reg.wrAcked && st_reg.cfgValid) |=> slowRateSelect == $past(st_reg.cfgRate)) // R02
        else $error("configuration byte not applied at Stop");
    a_cfg_keep: assert property ((stopSeen && !st_reg.cfgValid) |=> $stable(slowRateSelect)) // R07
        else $error("configuration changed without a data byte");
    a_global_ack: assert property ((st_reg.phase == PH_ADDR && sclRise && !stopSeen && !startSeen && st_reg.bitCnt == 3'h7
        && inByte == {GLOBAL_ADDR, 1'b0} && !st_reg.converting) |=> st_reg.phase == PH_ADDR_ACK) // R04
        else $error("global write address not selected");
    a_nak_inert: assert property ((stopSeen && !st_reg.wrAcked && !st_reg.rdAcked) |=> ($past(convBusy) || !convBusy)
        && $stable(slowRateSelect)) // R13
        else $error("NAKed transfer restarted or reconfigured");
    a_read_msb: assert property ((st_reg.phase == PH_RDATA && sclFall && !stopSeen && !startSeen)
        |=> sdaOe == !$past(st_reg.dataOut[RESULT_W-1])) // R11
        else $error("read bit not driven from result MSB");
    a_read_restart: assert property ((st_reg.phase == PH_RMACK && sclRise && st_reg.ackPh && st_reg.byteIdx
        && !stopSeen && !startSeen) |=> convBusy && st_reg.acc == 17'h0) // R12
        else $error("no restart after 16 bits read");
    a_sinc_result: assert property (convEnd |=> !convBusy && resultData == scaleSum($past(st_reg.acc), slowRateSelect)) // R08
        else $error("result differs from sinc1 sum");

    c_global_sync: cover property (st_reg.phase == PH_ADDR_ACK && st_reg.sdaOe && st_reg.shiftIn[7:1] == GLOBAL_ADDR);
    c_read_done: cover property (st_reg.phase == PH_RMACK && sclRise && st_reg.ackPh && st_reg.byteIdx);
    c_cfg_slow: cover property (stopSeen && st_reg.wrAcked && st_reg.cfgValid && st_reg.cfgRate);

endmodule : adc_i2c_conversion_restart

`default_nettype wire

// ### testbench/i2c_master_model.sv
`timescale 1ns/10ps
`default_nettype none

// Bus master: SCL push-pull, SDA open drain (pull low only)
module i2c_master_model (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sdaPull
);
    // Idle bus, SCL stands high outside frames
    initial begin
        scl = 1'b1;
        sdaPull = 1'b0;
    end

    // Eight clocks keeps every SCL phase above the detection floor
    task automatic half();
        repeat (8) @(posedge clk);
        #1;
    endtask : half

    // Start or repeated start
    task automatic start();
        sdaPull = 1'b0;
        half();
        scl = 1'b1;
        half();
        sdaPull = 1'b1;
        half();
        scl = 1'b0;
    endtask : start

    // Stop always raises SDA while SCL is high
    task automatic stop();
        half();
        sdaPull = 1'b1;
        half();
        scl = 1'b1;
        half();
        sdaPull = 1'b0;
        half();
    endtask : stop

    // Data changes only while SCL is low
    task automatic xfer_bit(input logic b, output logic r);
        half();
        sdaPull = ~b;
        half();
        scl = 1'b1;
        half();
        r = sda;
        scl = 1'b0;
    endtask : xfer_bit

    // Byte out, SDA released in the ninth clock for the slave's answer
    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) xfer_bit(d[i], r);
        xfer_bit(1'b1, r);
        ack = ~r;
    endtask : write_byte

    // Byte in, MSB first, then the master's own ack or nak
    task automatic read_byte(input logic ackIt, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(1'b1, r);
            d = {d[6:0], r};
        end
        xfer_bit(~ackIt, r);
    endtask : read_byte
endmodule : i2c_master_model

`default_nettype wire

// ### testbench/adc_i2c_conversion_restart_test.sv
`timescale 1ns/10ps
`default_nettype none

module adc_i2c_conversion_restart_test;
    import adc_i2c_pkg::*;
    localparam int NS = 400; // Fast conversion 400 clk, slow 800
    logic clk, rst, modBit, sdaOut, sdaOe, slowRateSelect, convBusy, ack;
    logic [RESULT_W-1:0] resultData;
    logic [7:0] hi, lo;
    wire logic scl, sdaPull, sda;
    int nErrors = 0, totalChecks = 0, n;

    // Pull-up wins unless someone pulls low
    assign sda = ~(sdaOe | sdaPull);

    i2c_master_model m (.clk(clk), .sda(sda), .scl(scl), .sdaPull(sdaPull));
    adc_i2c_conversion_restart #(.SAMPLE_DIV(1), .CONV_SAMPLES(NS)) i_dut (.clk(clk), .rst(rst), .sclIn(scl),
        .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .modBit(modBit), .slowRateSelect(slowRateSelect),
        .convBusy(convBusy), .resultData(resultData));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        totalChecks++;
        if (got !== exp) begin
            nErrors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Counts busy cycles, bounded so a stuck converter cannot hang the run
    task automatic busy_len(output int c);
        c = 0;
        while (convBusy === 1'b1 && c < 2000) begin
            @(posedge clk);
            #1;
            c++;
        end
        if (c >= 2000) chk(16'h0, 16'h1);
    endtask : busy_len

    task automatic t_reset();
        chk(slowRateSelect, 1'b0);
        chk(convBusy, 1'b1);
        chk(sdaOut, 1'b0);
        busy_len(n);
    endtask : t_reset

    // Own-address write with slow byte, then the NAKed write while busy
    task automatic t_write_cfg_then_nak();
        m.start();
        m.write_byte({OWN_ADDR, 1'b0}, ack);
        chk(ack, 1'b1);
        m.write_byte(8'h80, ack);
        m.stop();
        repeat (6) @(posedge clk);
        #1;
        chk({slowRateSelect, convBusy}, 2'b11);
        chk(resultData, NS);
        m.start();
        m.write_byte({OWN_ADDR, 1'b0}, ack);
        chk(ack, 1'b0);
        m.write_byte(8'h00, ack);
        m.stop();
        repeat (6) @(posedge clk);
        #1;
        chk(slowRateSelect, 1'b1);
        busy_len(n);
        chk(n > 0 && n < 700, 1'b1);
    endtask : t_write_cfg_then_nak

    // Global call with a rate byte, then a bare global call
    task automatic t_global();
        m.start();
        m.write_byte({GLOBAL_ADDR, 1'b0}, ack);
        chk(ack, 1'b1);
        m.write_byte(8'h80, ack);
        m.stop();
        repeat (6) @(posedge clk);
        #1;
        chk({slowRateSelect, convBusy}, 2'b11);
        busy_len(n);
        chk(n > 780 && n <= 2 * NS, 1'b1);
        m.start();
        m.write_byte({GLOBAL_ADDR, 1'b0}, ack);
        chk(ack, 1'b1);
        m.stop();
        repeat (6) @(posedge clk);
        #1;
        chk({slowRateSelect, convBusy}, 2'b11);
        busy_len(n);
    endtask : t_global

    // Write fast byte, repeated start, full 16-bit read, then read back an all-zero fast result
    task automatic t_write_read();
        // Bitstream held at zero from here, so the next conversion sees only zeros
        modBit = 1'b0;
        m.start();
        m.write_byte({OWN_ADDR, 1'b0}, ack);
        m.write_byte(8'h00, ack);
        m.start();
        m.write_byte({OWN_ADDR, 1'b1}, ack);
        chk(ack, 1'b1);
        m.read_byte(1'b1, hi);
        chk(convBusy, 1'b0);
        m.read_byte(1'b0, lo);
        repeat (6) @(posedge clk);
        #1;
        chk({hi, lo}, NS);
        chk({slowRateSelect, convBusy}, 2'b01);
        m.stop();
        busy_len(n);
        // Restart came at the read's end, some 43 cycles before counting; one at Stop would show near 396
        chk(n > 340 && n < 380, 1'b1);
        m.start();
        m.write_byte({OWN_ADDR, 1'b1}, ack);
        chk(ack, 1'b1);
        m.read_byte(1'b1, hi);
        m.read_byte(1'b0, lo);
        m.stop();
        chk({hi, lo}, 16'h0000);
        chk(resultData, 16'h0000);
    endtask : t_write_read

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", totalChecks, nErrors);
        if (nErrors == 0 && totalChecks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish

    // Watchdog well past the roughly 6300 cycles the tests take
    initial begin
        #(60000 * 50);
        nErrors++;
        tally_and_finish();
    end

    // Bitstream at one until the last scenario, so those results equal the fast sample count
    initial begin
        rst = 1'b1;
        modBit = 1'b1;
        repeat (10) @(posedge clk);
        #1;
        rst = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        t_reset();
        t_write_cfg_then_nak();
        t_global();
        t_write_read();
        tally_and_finish();
    end
endmodule : adc_i2c_conversion_restart_test

`default_nettype wire
